// ### inc/pa4_pkg.sv
// Package of constants and helpers for the eight-bit port with analog and wakeup sharing
package pa4_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned PA4_PIN_W = 8;
    localparam int unsigned PA4_ADR_W = 16;
    localparam int unsigned PA4_DAT_W = 32;
    localparam int unsigned PA4_IDX_W = 14;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [PA4_IDX_W-1:0] PA4_IDX_OUTPUT_LATCH  = 14'h0004;
    localparam logic [PA4_IDX_W-1:0] PA4_IDX_PIN_STATE     = 14'h0011;
    localparam logic [PA4_IDX_W-1:0] PA4_IDX_DIRECTION     = 14'h0f1e;
    localparam logic [PA4_IDX_W-1:0] PA4_IDX_PULLUP_ENABLE = 14'h0f2b;
    localparam logic [PA4_IDX_W-1:0] PA4_IDX_FUNCTION_SEL  = 14'h0f38;
    localparam logic [PA4_IDX_W-1:0] PA4_IDX_PAD_STATUS    = 14'h0f40;

    // ==========================================================
    // Values after reset
    localparam logic [PA4_PIN_W-1:0] PA4_RST_OUTPUT_LATCH  = 8'h00;
    localparam logic [PA4_PIN_W-1:0] PA4_RST_DIRECTION     = 8'h00;
    localparam logic [PA4_PIN_W-1:0] PA4_RST_PULLUP_ENABLE = 8'h00;
    localparam logic [PA4_PIN_W-1:0] PA4_RST_FUNCTION_SEL  = 8'h00;
    localparam logic [PA4_PIN_W-1:0] PA4_RST_SYNC          = 8'h00;
    localparam logic [PA4_DAT_W-1:0] PA4_RST_READ_DATA     = 32'h0000_0000;

    // ==========================================================
    // Field positions in the pad status register
    localparam int unsigned PA4_STAT_OE_LSB = 0;
    localparam int unsigned PA4_STAT_PU_LSB = 8;
    localparam int unsigned PA4_STAT_AN_LSB = 16;

    // ==========================================================
    // Helpers
    function automatic logic pa4_hit(input logic [PA4_ADR_W-1:0] adr,
                                     input logic [PA4_IDX_W-1:0] idx);
        return adr[PA4_ADR_W-1:2] == idx;
    endfunction

    function automatic logic [PA4_DAT_W-1:0] pa4_widen(input logic [PA4_PIN_W-1:0] v);
        return {{(PA4_DAT_W-PA4_PIN_W){1'b0}}, v};
    endfunction

endpackage

// ### design/pa4_sync.sv
// Two-stage synchroniser for the eight pin levels
`timescale 1ns/100ps
module pa4_sync
    import pa4_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [PA4_PIN_W-1:0] async_i,
    output logic      [PA4_PIN_W-1:0] sync_o
);
    // ==========================================================
    // Stages
    logic [PA4_PIN_W-1:0] meta_q;
    logic [PA4_PIN_W-1:0] sync_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= PA4_RST_SYNC;
            sync_q <= PA4_RST_SYNC;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // pa4_sync

// ### design/pa4_pin_cell.sv
// One pad control cell: driver, output enable, pull-up and analog routing
`timescale 1ns/100ps
module pa4_pin_cell (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic latch_i,
    input  wire logic dir_i,
    input  wire logic fsel_i,
    input  wire logic pu_en_i,
    input  wire logic wake_en_i,
    output logic      pad_o,
    output logic      pad_oe_o,
    output logic      pullup_o,
    output logic      analog_o
);
    // ==========================================================
    // Registered pad controls
    logic pad_q;
    logic pad_oe_q;
    logic pullup_q;
    logic analog_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_q    <= 1'b0;
            pad_oe_q <= 1'b0;
        end else begin
            pad_q    <= latch_i;
            pad_oe_q <= dir_i & ~fsel_i;
        end
    end

    // Pull-up only in wakeup use or plain digital input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_q <= 1'b0;
        end else begin
            pullup_q <= pu_en_i & (wake_en_i | (~fsel_i & ~dir_i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_q <= 1'b0;
        end else begin
            analog_q <= fsel_i;
        end
    end

    assign pad_o    = pad_q;
    assign pad_oe_o = pad_oe_q;
    assign pullup_o = pullup_q;
    assign analog_o = analog_q;

endmodule // pa4_pin_cell

// ### design/pa4_port.sv
// Eight-bit port with analog input and key-on wakeup sharing, Wishbone register slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
// Functional notes
// - Eight pins, each with own direction bit
// - Pin i feeds analog channel i, wakeup i
// - Output mode drives the output latch level only while function select is 0
// - Direction 0 input, 1 output, reset 0
// - Enabled wakeup works whatever the direction
// - Enabled wakeup works whatever the function select
// - Pull-up enable 0 keeps pull-up off
// - Pull-up on only for wakeup or input
// - Pin state reads pin only when both 0
module pa4_port
    import pa4_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone classic slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [PA4_ADR_W-1:0] adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [PA4_DAT_W-1:0] dat_i,
    output logic      [PA4_DAT_W-1:0] dat_o,
    output logic                      ack_o,
    // Pads
    input  wire logic [PA4_PIN_W-1:0] pin_i,
    output logic      [PA4_PIN_W-1:0] pin_o,
    output logic      [PA4_PIN_W-1:0] pin_oe_o,
    output logic      [PA4_PIN_W-1:0] pullup_on_o,
    // Analog converter side
    output logic      [PA4_PIN_W-1:0] analog_channel_input_en_o,
    // Wakeup controller side
    input  wire logic [PA4_PIN_W-1:0] wakeup_enable_bit_i,
    output logic      [PA4_PIN_W-1:0] key_wakeup_input_o
);

    // ==========================================================
    // Registers
    logic [PA4_PIN_W-1:0] output_latch_q;
    logic [PA4_PIN_W-1:0] direction_bits_q;
    logic [PA4_PIN_W-1:0] pullup_enable_bits_q;
    logic [PA4_PIN_W-1:0] function_select_bits_q;
    logic [PA4_DAT_W-1:0] rd_data_q;
    logic                 ack_q;

    // ==========================================================
    // Pin side signals
    logic [PA4_PIN_W-1:0] pin_sync;
    logic [PA4_PIN_W-1:0] pin_state_read;
    logic [PA4_PIN_W-1:0] pad_oe;
    logic [PA4_PIN_W-1:0] pad_pu;
    logic [PA4_PIN_W-1:0] pad_an;

    // ==========================================================
    // Bus decode
    logic                 req;
    logic                 wr_take;
    logic                 wr_lane0;
    logic [PA4_DAT_W-1:0] rd_data_d;

    assign req      = cyc_i & stb_i;
    // Write lands at the edge where the master sees ack
    assign wr_take  = req & we_i & ack_q;
    assign wr_lane0 = wr_take & sel_i[0];

    // ==========================================================
    // Pin input synchroniser
    pa4_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pin_i),
        .sync_o  (pin_sync)
    );

    // ==========================================================
    // Pad cells, one per bit
    for (genvar i = 0; i < PA4_PIN_W; i++) begin : g_pin
        pa4_pin_cell u_cell (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .latch_i   (output_latch_q[i]),
            .dir_i     (direction_bits_q[i]),
            .fsel_i    (function_select_bits_q[i]),
            .pu_en_i   (pullup_enable_bits_q[i]),
            .wake_en_i (wakeup_enable_bit_i[i]),
            .pad_o     (pin_o[i]),
            .pad_oe_o  (pad_oe[i]),
            .pullup_o  (pad_pu[i]),
            .analog_o  (pad_an[i])
        );
    end

    assign pin_oe_o                  = pad_oe;
    assign pullup_on_o               = pad_pu;
    assign analog_channel_input_en_o = pad_an;

    // ==========================================================
    // Wakeup path
    // Raw synced level goes straight out, untouched by direction or function
    // select, so the wakeup controller sees the pin in every mode.
    assign key_wakeup_input_o = pin_sync;

    // ==========================================================
    // Pin state view
    assign pin_state_read = pin_sync & ~direction_bits_q & ~function_select_bits_q;

    // ==========================================================
    // Output latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_latch_q <= PA4_RST_OUTPUT_LATCH;
        end else if (wr_lane0 && pa4_hit(adr_i, PA4_IDX_OUTPUT_LATCH)) begin
            output_latch_q <= dat_i[PA4_PIN_W-1:0];
        end
    end

    // ==========================================================
    // Direction control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            direction_bits_q <= PA4_RST_DIRECTION;
        end else if (wr_lane0 && pa4_hit(adr_i, PA4_IDX_DIRECTION)) begin
            direction_bits_q <= dat_i[PA4_PIN_W-1:0];
        end
    end

    // ==========================================================
    // Pull-up enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_enable_bits_q <= PA4_RST_PULLUP_ENABLE;
        end else if (wr_lane0 && pa4_hit(adr_i, PA4_IDX_PULLUP_ENABLE)) begin
            pullup_enable_bits_q <= dat_i[PA4_PIN_W-1:0];
        end
    end

    // ==========================================================
    // Function select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            function_select_bits_q <= PA4_RST_FUNCTION_SEL;
        end else if (wr_lane0 && pa4_hit(adr_i, PA4_IDX_FUNCTION_SEL)) begin
            function_select_bits_q <= dat_i[PA4_PIN_W-1:0];
        end
    end
    // Pin state and pad status have no write branch at all

    // ==========================================================
    // Read multiplexer
    always_comb begin
        rd_data_d = PA4_RST_READ_DATA;
        if (pa4_hit(adr_i, PA4_IDX_OUTPUT_LATCH)) begin
            rd_data_d = pa4_widen(output_latch_q);
        end else if (pa4_hit(adr_i, PA4_IDX_PIN_STATE)) begin
            rd_data_d = pa4_widen(pin_state_read);
        end else if (pa4_hit(adr_i, PA4_IDX_DIRECTION)) begin
            rd_data_d = pa4_widen(direction_bits_q);
        end else if (pa4_hit(adr_i, PA4_IDX_PULLUP_ENABLE)) begin
            rd_data_d = pa4_widen(pullup_enable_bits_q);
        end else if (pa4_hit(adr_i, PA4_IDX_FUNCTION_SEL)) begin
            rd_data_d = pa4_widen(function_select_bits_q);
        end else if (pa4_hit(adr_i, PA4_IDX_PAD_STATUS)) begin
            rd_data_d[PA4_STAT_OE_LSB +: PA4_PIN_W] = pad_oe;
            rd_data_d[PA4_STAT_PU_LSB +: PA4_PIN_W] = pad_pu;
            rd_data_d[PA4_STAT_AN_LSB +: PA4_PIN_W] = pad_an;
        end
    end

    // ==========================================================
    // Handshake
    // One wait state: ack rises the cycle after the request, falls the next.
    // Unmapped addresses are acked too, reading zero, so a bad access never hangs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_q <= PA4_RST_READ_DATA;
        end else if (req && !ack_q) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rd_data_q;

endmodule // pa4_port

// ### testbench/pa4_port_props.sv
// Checker for the eight-bit port, attached to its ports
`timescale 1ns/100ps
module pa4_port_props
    import pa4_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 cyc_i,
    input wire logic                 stb_i,
    input wire logic                 we_i,
    input wire logic [PA4_ADR_W-1:0] adr_i,
    input wire logic [3:0]           sel_i,
    input wire logic [PA4_DAT_W-1:0] dat_i,
    input wire logic [PA4_DAT_W-1:0] dat_o,
    input wire logic                 ack_o,
    input wire logic [PA4_PIN_W-1:0] pin_i,
    input wire logic [PA4_PIN_W-1:0] pin_o,
    input wire logic [PA4_PIN_W-1:0] pin_oe_o,
    input wire logic [PA4_PIN_W-1:0] pullup_on_o,
    input wire logic [PA4_PIN_W-1:0] analog_channel_input_en_o,
    input wire logic [PA4_PIN_W-1:0] wakeup_enable_bit_i,
    input wire logic [PA4_PIN_W-1:0] key_wakeup_input_o
);
    // ==========================================================
    // Sequences
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pin_read;
        cyc_i && stb_i && !we_i && !ack_o && adr_i[15:2] == PA4_IDX_PIN_STATE;
    endsequence
    sequence s_latch_wr;
        ack_o && we_i && sel_i[0] && adr_i[15:2] == PA4_IDX_OUTPUT_LATCH;
    endsequence
    // ==========================================================
    // Assertions
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_dat_upper_zero: assert property (
        ack_o && adr_i[15:2] != PA4_IDX_PAD_STATUS |-> dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_stat_top_zero: assert property (
        ack_o && adr_i[15:2] == PA4_IDX_PAD_STATUS |-> dat_o[31:24] == 8'h00)
        else $error("pad status top byte set");
    a_latch_drive: assert property (
        s_latch_wr |-> ##2 pin_o == $past(dat_i[7:0], 2))
        else $error("pad level differs from latch write");
    a_oe_not_analog: assert property (
        (pin_oe_o & analog_channel_input_en_o) == 8'h00)
        else $error("driver on for analog pin");
    a_pullup_gated: assert property (
        (pullup_on_o & (pin_oe_o | analog_channel_input_en_o)
         & ~$past(wakeup_enable_bit_i)) == 8'h00)
        else $error("pull-up on outside input mode");
    a_pin_read_zero: assert property (
        s_pin_read |=> ack_o && (dat_o[7:0] & (pin_oe_o | analog_channel_input_en_o)) == 8'h00)
        else $error("pin state not zero for non-input pin");
    a_wake_follows: assert property (
        !$past(rst_i) && !$past(rst_i, 2) |-> key_wakeup_input_o == $past(pin_i, 2))
        else $error("wakeup line does not follow pin");
endmodule // pa4_port_props

bind pa4_port pa4_port_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .pin_i, .pin_o, .pin_oe_o, .pullup_on_o, .analog_channel_input_en_o,
    .wakeup_enable_bit_i, .key_wakeup_input_o);

// ### testbench/pa4_pad_model.sv
// Model of the pads and the outside drivers seen by the port
`timescale 1ns/100ps
module pa4_pad_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] lvl_o
);
    // ==========================================================
    // Pad level
    logic [7:0] last_q;
    always_ff @(posedge clk_i) begin
        last_q <= lvl_o;
    end
    // Driver wins, then outside source, then pull-up; a floating pin drifts
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
                 | (~oe_i & ~ext_en_i & (pu_i | ~last_q));
endmodule // pa4_pad_model

// ### testbench/tb_top.sv
// Self-checking testbench for the eight-bit port
`timescale 1ns/100ps
module tb_top;
    import pa4_pkg::*;
    // ==========================================================
    // Signals
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [15:0] adr_i = 16'h0000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [7:0]  pin_i, pin_o, pin_oe_o, pullup_on_o, analog_channel_input_en_o;
    logic [7:0]  key_wakeup_input_o;
    logic [7:0]  wakeup_enable_bit_i = 8'h00;
    logic [7:0]  ext_q = 8'h00;
    logic [7:0]  ext_en_q = 8'h00;
    logic [31:0] rd;
    int          num_errors = 0;
    int          checked = 0;
    int          seed = 79;
    int          ticks = 0;
    int          wk, ext, oe, pue, lvl;
    int          sh[4] = '{0, 0, 0, 0};
    logic [13:0] regs[$] = '{PA4_IDX_OUTPUT_LATCH, PA4_IDX_DIRECTION,
                             PA4_IDX_PULLUP_ENABLE, PA4_IDX_FUNCTION_SEL};

    pa4_port dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .pin_i, .pin_o, .pin_oe_o, .pullup_on_o, .analog_channel_input_en_o,
        .wakeup_enable_bit_i, .key_wakeup_input_o);
    pa4_pad_model pad_u (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o), .pu_i(pullup_on_o),
        .ext_i(ext_q), .ext_en_i(ext_en_q), .lvl_o(pin_i));

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Waits on ack with no fixed count; the cycle ceiling cuts a hang
    task automatic wb(input logic w, input logic [13:0] ix, input int d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {ix, 2'b00};
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic readback;
        foreach (regs[k]) begin
            wb(1'b0, regs[k], 0, rd);
            chk("register", sh[k], rd);
        end
    endtask

    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Clock, ceiling and sequence
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 5000) begin
            num_errors++;
            summarize;
        end
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        readback;
        wb(1'b0, 14'h0100, 0, rd);
        chk("unmapped", 0, rd);
        repeat (24) begin
            foreach (sh[k]) sh[k] = $random(seed) & 'hff;
            wk = $random(seed) & 'hff;
            ext = $random(seed) & 'hff;
            pue = sh[2] & (wk | (~sh[3] & ~sh[1])) & 'hff;
            wakeup_enable_bit_i <= wk[7:0];
            ext_q <= ext[7:0];
            ext_en_q <= ~pue[7:0];
            foreach (regs[k]) wb(1'b1, regs[k], sh[k], rd);
            wb(1'b1, PA4_IDX_PIN_STATE, 'hff, rd);
            repeat (4) @(posedge clk_i);
            oe = sh[1] & ~sh[3] & 'hff;
            lvl = (oe & sh[0]) | (~oe & pue) | (~oe & ~pue & ext);
            chk("pin_o", sh[0], pin_o);
            chk("pin_oe_o", oe, pin_oe_o);
            chk("pullup", pue, pullup_on_o);
            chk("analog", sh[3], analog_channel_input_en_o);
            chk("wakeup", lvl & 'hff, key_wakeup_input_o);
            wb(1'b0, PA4_IDX_PIN_STATE, 0, rd);
            chk("pin_state", lvl & ~sh[1] & ~sh[3] & 'hff, rd);
            wb(1'b0, PA4_IDX_PAD_STATUS, 0, rd);
            chk("pad_status", {sh[3][7:0], pue[7:0], oe[7:0]}, rd);
            readback;
        end
        summarize;
    end
endmodule // tb_top
